// ---- hw/rwl_pkg.sv ----
package rwl_pkg;

  // clock and time base
  localparam int unsigned CLK_FREQ_HZ  = 25_000_000;
  localparam int unsigned WDOG_TICK_US = 1000;
  localparam int unsigned WDOG_TICK_CYC =
    CLK_FREQ_HZ / 1_000_000 * WDOG_TICK_US;

  // warm-up lengths in oscillator cycles
  localparam int unsigned WARM_POR_LO_CYC   = 4096;
  localparam int unsigned WARM_POR_HI_CYC   = 16384;
  localparam int unsigned WARM_FAST_RC_CYC  = 128;
  localparam int unsigned WARM_FAST_XTL_CYC = 4096;

  // register port
  localparam int unsigned REG_ADDR_W = 6;
  localparam int unsigned REG_DATA_W = 4;
  localparam logic [5:0]  ADDR_WDOG  = 6'h1e;
  localparam int unsigned WDOG_FLAG_BIT = 3;
  localparam logic [2:0]  WDOG_PERIOD_RST = 3'h0;
  localparam logic        WDOG_FLAG_RST   = 1'b0;
  localparam int unsigned WDOG_MS_W       = 13;

  // synchroniser idle levels: {cmp, supply_low, pin_b}
  localparam logic [2:0] SYNC_RST = 3'h1;

  // option defaults held until the straps are taken
  localparam logic [2:0] CFG_OSC_TYPE_RST  = 3'h0;
  localparam logic       CFG_OSC_RANGE_RST = 1'b1;
  localparam logic       CFG_WDOG_EN_RST   = 1'b1;
  localparam logic       CFG_UV_EN_RST     = 1'b1;
  localparam logic       CFG_UV_LEVEL_RST  = 1'b1;
  localparam logic       CFG_RST_PIN_RST   = 1'b0;

  // oscillator type codes
  typedef enum logic [2:0] {
    OSC_EXT_CLK    = 3'h0,
    OSC_INT_RC     = 3'h3,
    OSC_EXT_RC     = 3'h4,
    OSC_CERAMIC    = 3'h5,
    OSC_CRYSTAL    = 3'h6,
    OSC_LF_CRYSTAL = 3'h7
  } rwl_osc_t;

  // power sequencer states
  typedef enum logic [2:0] {
    ST_RESET = 3'h0,
    ST_WARM  = 3'h1,
    ST_RUN   = 3'h2,
    ST_HALT  = 3'h3,
    ST_STOP  = 3'h4
  } rwl_state_t;

  // timeout in ms for each period code
  function automatic logic [WDOG_MS_W-1:0] rwl_period_ms(
    input logic [2:0] sel
  );
    case (sel)
      3'h0:    rwl_period_ms = 13'h1000;
      3'h1:    rwl_period_ms = 13'h0400;
      3'h2:    rwl_period_ms = 13'h0100;
      3'h3:    rwl_period_ms = 13'h0080;
      3'h4:    rwl_period_ms = 13'h0040;
      3'h5:    rwl_period_ms = 13'h0010;
      3'h6:    rwl_period_ms = 13'h0004;
      default: rwl_period_ms = 13'h0001;
    endcase
  endfunction

endpackage

// ---- hw/rwl_supervisor.sv ----
// Implementation choice: strobed register access.
`timescale 1ns/1ps
module rwl_supervisor #(
  parameter int unsigned WDOG_TICK_CYCLES = rwl_pkg::WDOG_TICK_CYC,
  parameter int unsigned WARM_POR_HI      = rwl_pkg::WARM_POR_HI_CYC
) (
  input  wire logic                            clk,
  input  wire logic                            rst_b,
  // register port from the core
  input  wire logic [rwl_pkg::REG_ADDR_W-1:0]  reg_addr,
  input  wire logic [rwl_pkg::REG_DATA_W-1:0]  reg_wdata,
  input  wire logic                            reg_wr,
  input  wire logic                            reg_rd,
  output logic      [rwl_pkg::REG_DATA_W-1:0]  reg_rdata,
  // one-time option straps
  input  wire logic [2:0]                      cfg_osc_type,
  input  wire logic                            cfg_osc_range,
  input  wire logic                            cfg_wdog_enable,
  input  wire logic                            cfg_undervolt_enable,
  input  wire logic                            cfg_undervolt_level,
  input  wire logic                            cfg_reset_pin_enable,
  // asynchronous pins
  input  wire logic                            reset_pin_b,
  input  wire logic                            supply_low,
  input  wire logic                            comparator_result_bit,
  // same-clock inputs from the core and interrupt logic
  input  wire logic                            cmp_irq_enable,
  input  wire logic                            port_irq,
  input  wire logic                            irq_pending,
  input  wire logic                            halt_exec,
  input  wire logic                            stop_exec,
  // power and reset controls
  output logic                                 sys_reset,
  output logic                                 cpu_run,
  output logic                                 osc_run,
  output logic                                 periph_run,
  output logic                                 isr_entry,
  output logic                                 undervoltage_reset,
  output logic                                 undervoltage_threshold,
  output logic                                 pin_port_bit
);
  import rwl_pkg::*;

  // warm-up counter must hold the longest length
  // the low-range length is fixed, so it sets the
  // floor on the width even when the high range is shortened
  localparam int unsigned WARM_MAX = (WARM_POR_HI > WARM_POR_LO_CYC)
                                   ? WARM_POR_HI : WARM_POR_LO_CYC;
  localparam int unsigned WARM_W = $clog2(WARM_MAX + 1);
  localparam logic [WARM_W-1:0] WARM_ONE = WARM_W'(1);

  // synchroniser stages, bit order {cmp, supply, pin_b}
  logic [2:0] sync1_reg;    // first stage, read only by sync2
  logic [2:0] sync2_reg;    // second stage
  logic [2:0] sync3_reg;    // third stage
  logic [2:0] filt_reg;     // level once stages 2 and 3 agree

  // captured option straps
  logic       cfg_taken_reg;
  logic [2:0] osc_type_reg;
  logic       osc_range_reg;
  logic       wdog_en_reg;
  logic       uv_en_reg;
  logic       uv_level_reg;
  logic       rst_pin_opt_reg;

  // sequencer state
  rwl_state_t        state_reg;
  logic [WARM_W-1:0] warm_cnt_reg;   // cycles left in warm-up
  logic              lv_cause_reg;   // last reset came from supply
  logic              stop_warm_reg;  // warm-up after a stop wake
  logic              isr_entry_reg;

  // comparator change detection
  logic              cmp_prev_reg;
  logic              cmp_wake;

  // register file
  logic [2:0]        period_reg;
  logic              flag_reg;
  logic [3:0]        rdata_reg;
  logic              wdog_access;

  // decoded conditions
  logic              uv_active;
  logic              pin_active;
  logic              halt_wake;
  logic              stop_wake;
  logic              in_reset;
  logic [WARM_W-1:0] long_len;
  logic [WARM_W-1:0] fast_len;

  rwl_wdog_if wd_if ();

  // crystal and ceramic need the long restart
  function automatic logic needs_slow_start(input logic [2:0] t);
    needs_slow_start = (t == OSC_CERAMIC) || (t == OSC_CRYSTAL) ||
                       (t == OSC_LF_CRYSTAL);
  endfunction

  // three-stage pin synchroniser with agreement filter;
  // a glitch seen by only one stage never reaches filt
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_reg <= SYNC_RST;
      sync2_reg <= SYNC_RST;
      sync3_reg <= SYNC_RST;
      filt_reg  <= SYNC_RST;
    end else begin
      sync1_reg <= {comparator_result_bit, supply_low, reset_pin_b};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      filt_reg  <= (sync2_reg & sync3_reg) |
                   (filt_reg & (sync2_reg | sync3_reg));
    end
  end

  // straps are taken once, on the first edge after release,
  // since an async reset may only load constants
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_taken_reg   <= 1'b0;
      osc_type_reg    <= CFG_OSC_TYPE_RST;
      osc_range_reg   <= CFG_OSC_RANGE_RST;
      wdog_en_reg     <= CFG_WDOG_EN_RST;
      uv_en_reg       <= CFG_UV_EN_RST;
      uv_level_reg    <= CFG_UV_LEVEL_RST;
      rst_pin_opt_reg <= CFG_RST_PIN_RST;
    end else if (!cfg_taken_reg) begin
      cfg_taken_reg   <= 1'b1;
      osc_type_reg    <= cfg_osc_type;
      osc_range_reg   <= cfg_osc_range;
      wdog_en_reg     <= cfg_wdog_enable;
      uv_en_reg       <= cfg_undervolt_enable;
      uv_level_reg    <= cfg_undervolt_level;
      rst_pin_opt_reg <= cfg_reset_pin_enable;
    end
  end

  // reset sources, both level held
  assign uv_active  = uv_en_reg && filt_reg[1];
  assign pin_active = !rst_pin_opt_reg && !filt_reg[0];

  // warm-up lengths for the two families of cause
  assign long_len = osc_range_reg ? WARM_W'(WARM_POR_HI)
                                  : WARM_W'(WARM_POR_LO_CYC);
  assign fast_len = needs_slow_start(osc_type_reg)
                  ? WARM_W'(WARM_FAST_XTL_CYC)
                  : WARM_W'(WARM_FAST_RC_CYC);

  // comparator edge: either direction counts as a change
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cmp_prev_reg <= 1'b0;
    end else begin
      cmp_prev_reg <= filt_reg[2];
    end
  end

  assign cmp_wake  = cmp_irq_enable &&
                     (filt_reg[2] != cmp_prev_reg);
  // halt: any enabled source; the core folds its own enables in
  assign halt_wake = irq_pending || port_irq || cmp_wake;
  // stop: only sources that live without the main oscillator
  assign stop_wake = port_irq || cmp_wake;

  // power sequencer; pin and supply resets win over everything,
  // then a watchdog timeout, then the normal flow
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg     <= ST_RESET;
      warm_cnt_reg  <= '0;
      lv_cause_reg  <= 1'b0;
      stop_warm_reg <= 1'b0;
      isr_entry_reg <= 1'b0;
    end else begin
      isr_entry_reg <= 1'b0;
      if (uv_active || pin_active) begin
        // hold in reset while the source stays active
        state_reg     <= ST_RESET;
        lv_cause_reg  <= uv_active;
        stop_warm_reg <= 1'b0;
      end else if (wd_if.overflow) begin
        // full reset with the short restart, even out of stop
        state_reg     <= ST_WARM;
        warm_cnt_reg  <= fast_len;
        stop_warm_reg <= 1'b0;
      end else begin
        case (state_reg)
          ST_RESET: begin
            // wait for the straps before picking a length
            if (cfg_taken_reg) begin
              state_reg    <= ST_WARM;
              warm_cnt_reg <= lv_cause_reg ? fast_len
                                           : long_len;
            end
          end
          ST_WARM: begin
            if (warm_cnt_reg == WARM_ONE) begin
              state_reg     <= ST_RUN;
              // stop wake enters its service routine first
              isr_entry_reg <= stop_warm_reg;
              stop_warm_reg <= 1'b0;
            end else begin
              warm_cnt_reg <= warm_cnt_reg - WARM_ONE;
            end
          end
          ST_RUN: begin
            // stop takes priority if both arrive together
            if (stop_exec) begin
              state_reg <= ST_STOP;
            end else if (halt_exec) begin
              state_reg <= ST_HALT;
            end
          end
          ST_HALT: begin
            // oscillator still runs, so no warm-up is needed
            if (halt_wake) begin
              state_reg     <= ST_RUN;
              isr_entry_reg <= 1'b1;
            end
          end
          ST_STOP: begin
            if (stop_wake) begin
              state_reg     <= ST_WARM;
              warm_cnt_reg  <= fast_len;
              stop_warm_reg <= 1'b1;
            end
          end
          default: begin
            state_reg <= ST_RESET;
          end
        endcase
      end
    end
  end

  // a stop-wake warm-up is not a reset: registers keep values
  assign in_reset = (state_reg == ST_RESET) ||
                    ((state_reg == ST_WARM) && !stop_warm_reg);

  // access to the watchdog register restarts the watchdog, read or write
  assign wdog_access = (reg_wr || reg_rd) && !in_reset &&
                       (reg_addr == ADDR_WDOG);

  // period field; back to default on every device reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      period_reg <= WDOG_PERIOD_RST;
    end else if (in_reset) begin
      period_reg <= WDOG_PERIOD_RST;
    end else if (reg_wr && (reg_addr == ADDR_WDOG)) begin
      period_reg <= reg_wdata[2:0];
    end
  end

  // overflow flag: cleared only by power-on, so it survives
  // the reset it caused; writes to bit 3 are dropped
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flag_reg <= WDOG_FLAG_RST;
    end else if (wd_if.overflow) begin
      flag_reg <= 1'b1;
    end
  end

  // read data valid the cycle after the strobe, zero otherwise;
  // unmapped addresses read as zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_reg <= '0;
    end else if (reg_rd && (reg_addr == ADDR_WDOG)) begin
      rdata_reg <= {flag_reg, period_reg};
    end else begin
      rdata_reg <= '0;
    end
  end

  // watchdog is held reloaded while the device is in reset
  assign wd_if.enable     = wdog_en_reg;
  assign wd_if.restart    = in_reset || wdog_access;
  // a write reloads with the code being written, not the old one
  assign wd_if.period_sel = (wdog_access && reg_wr) ? reg_wdata[2:0]
                                                    : period_reg;

  rwl_wdog #(
    .TICK_CYCLES (WDOG_TICK_CYCLES)
  ) u_wdog (
    .clk   (clk),
    .rst_b (rst_b),
    .wd    (wd_if.wdog)
  );

  // controls decoded straight from state flops
  assign reg_rdata  = rdata_reg;
  assign sys_reset  = in_reset;
  assign cpu_run    = (state_reg == ST_RUN);
  // main oscillator stops only in stop; watchdog is unaffected
  assign osc_run    = (state_reg != ST_STOP);
  // timers, converter keep going in halt, freeze in stop
  assign periph_run = (state_reg == ST_RUN) ||
                      (state_reg == ST_HALT);
  assign isr_entry  = isr_entry_reg;
  assign undervoltage_reset     = uv_active;
  assign undervoltage_threshold = uv_level_reg;
  // when the pin is not a reset it reads as a port bit
  assign pin_port_bit = rst_pin_opt_reg ? filt_reg[0] : 1'b1;

endmodule

// ---- hw/rwl_wdog.sv ----
`timescale 1ns/1ps
module rwl_wdog #(
  parameter int unsigned TICK_CYCLES = rwl_pkg::WDOG_TICK_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  rwl_wdog_if.wdog wd
);
  import rwl_pkg::*;

  localparam int unsigned DIV_W = $clog2(TICK_CYCLES + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYCLES - 1);

  logic [DIV_W-1:0]     div_reg;  // stands in for the private rc clock
  logic [WDOG_MS_W-1:0] ms_reg;   // remaining ms before overflow
  logic                 tick;     // one pulse per ms

  assign tick = (div_reg == DIV_LAST);

  // divider restarts with the count so timeouts are exact
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_reg <= '0;
    end else if (!wd.enable || wd.restart || tick) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  // ms down-counter; runs in run, halt and stop when enabled, held reloaded in reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ms_reg <= rwl_period_ms(WDOG_PERIOD_RST);
    end else if (!wd.enable || wd.restart) begin
      ms_reg <= rwl_period_ms(wd.period_sel);
    end else if (tick) begin
      if (ms_reg == 13'h0001) begin
        ms_reg <= rwl_period_ms(wd.period_sel);
      end else begin
        ms_reg <= ms_reg - 1'b1;
      end
    end
  end

  // overflow pulse, registered
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wd.overflow <= 1'b0;
    end else begin
      wd.overflow <= wd.enable && !wd.restart && tick &&
                     (ms_reg == 13'h0001);
    end
  end
endmodule

// ---- hw/rwl_wdog_if.sv ----
`timescale 1ns/1ps
// watchdog control bundle between sequencer and counter
interface rwl_wdog_if;
  logic       enable;      // option enable
  logic       restart;     // reload pulse or level
  logic [2:0] period_sel;  // timeout code
  logic       overflow;    // one-cycle timeout pulse
  modport ctrl (output enable, output restart,
                output period_sel, input overflow);
  modport wdog (input enable, input restart,
                input period_sel, output overflow);
endinterface

// ---- verification/rwl_core_model.sv ----
`timescale 1ns/1ps
// core model: register port master and halt/stop strobes
module rwl_core_model (
  input  wire logic       clk,
  input  wire logic [3:0] reg_rdata,
  output logic      [5:0] reg_addr,
  output logic      [3:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic            halt_exec,
  output logic            stop_exec
);
  // quiet bus from time zero
  initial begin
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    halt_exec = 1'b0;
    stop_exec = 1'b0;
  end

  // one-cycle write; returns on the edge that takes it
  task automatic wr(input logic [5:0] a, input logic [3:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // one-cycle read; data held only in the following cycle
  task automatic rd(input logic [5:0] a, output logic [3:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // single instruction strobe
  task automatic exec(input logic h, input logic s);
    @(posedge clk);
    halt_exec <= h;
    stop_exec <= s;
    @(posedge clk);
    halt_exec <= 1'b0;
    stop_exec <= 1'b0;
  endtask
endmodule

// ---- verification/rwl_supervisor_asserts.sv ----
`timescale 1ns/1ps
// watches the supervisor pins for sequencing slips
module rwl_supervisor_asserts (
  input wire logic                           clk,
  input wire logic                           rst_b,
  input wire logic                           reg_rd,
  input wire logic [rwl_pkg::REG_DATA_W-1:0] reg_rdata,
  input wire logic                           cfg_undervolt_level,
  input wire logic                           cfg_reset_pin_enable,
  input wire logic                           cmp_irq_enable,
  input wire logic                           port_irq,
  input wire logic                           halt_exec,
  input wire logic                           stop_exec,
  input wire logic                           sys_reset,
  input wire logic                           cpu_run,
  input wire logic                           osc_run,
  input wire logic                           periph_run,
  input wire logic                           isr_entry,
  input wire logic                           undervoltage_reset,
  input wire logic                           undervoltage_threshold,
  input wire logic                           pin_port_bit
);
  import rwl_pkg::*;
  // one domain, so clock and reset are stated once
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  run_clean_a: assert property (
    cpu_run |-> !sys_reset && osc_run && periph_run)
    else $error("core runs during reset or with clocks off");
  rdata_idle_a: assert property (
    !$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data not idle outside the answer cycle");
  halt_enter_a: assert property (
    cpu_run && halt_exec && !stop_exec |=> !cpu_run)
    else $error("halt did not stop the core");
  stop_enter_a: assert property (
    cpu_run && stop_exec |=> !osc_run || sys_reset)
    else $error("stop did not stop the oscillator");
  stop_hold_a: assert property (
    !osc_run && !port_irq && !cmp_irq_enable |=> !osc_run || sys_reset)
    else $error("stop left without a permitted wake source");
  isr_pulse_a: assert property (
    isr_entry |-> cpu_run ##1 !isr_entry)
    else $error("service entry not a single running cycle");
  uv_reset_a: assert property (
    undervoltage_reset |=> sys_reset)
    else $error("undervoltage active without system reset");
  uv_level_a: assert property (
    !sys_reset |-> undervoltage_threshold == cfg_undervolt_level)
    else $error("threshold select does not follow the option");
  pin_port_a: assert property (
    !cfg_reset_pin_enable |-> pin_port_bit)
    else $error("port bit moves while the pin is a reset");

  // main scenarios reached
  halt_seen_c: cover property (cpu_run && halt_exec);
  wake_seen_c: cover property (isr_entry);
  uv_seen_c: cover property (undervoltage_reset);
endmodule

bind rwl_supervisor rwl_supervisor_asserts u_chk (
  .clk(clk), .rst_b(rst_b), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .cfg_undervolt_level(cfg_undervolt_level),
  .cfg_reset_pin_enable(cfg_reset_pin_enable),
  .cmp_irq_enable(cmp_irq_enable), .port_irq(port_irq),
  .halt_exec(halt_exec), .stop_exec(stop_exec), .sys_reset(sys_reset),
  .cpu_run(cpu_run), .osc_run(osc_run), .periph_run(periph_run),
  .isr_entry(isr_entry), .undervoltage_reset(undervoltage_reset),
  .undervoltage_threshold(undervoltage_threshold),
  .pin_port_bit(pin_port_bit)
);

// ---- verification/rwl_supervisor_tb.sv ----
`timescale 1ns/1ps
// bench for the reset and power supervisor
module rwl_supervisor_tb;
  import rwl_pkg::*;
  localparam int TICK = 4;    // shortened watchdog tick
  localparam int POR_HI = 64; // shortened high-range warm-up
  logic        clk, rst_b, reg_wr, reg_rd, halt_exec, stop_exec;
  logic [5:0]  reg_addr;
  logic [3:0]  reg_wdata, reg_rdata, d, d2;
  logic [2:0]  cfg_osc_type;
  logic        cfg_osc_range, cfg_wdog_enable, cfg_undervolt_enable;
  logic        cfg_undervolt_level, cfg_reset_pin_enable;
  logic        reset_pin_b, supply_low, comparator_result_bit;
  logic        cmp_irq_enable, port_irq, irq_pending;
  logic        sys_reset, cpu_run, osc_run, periph_run, isr_entry;
  logic        undervoltage_reset, undervoltage_threshold, pin_port_bit;
  logic [15:0] lf = 16'hd37e; // fixed seed
  int          n_errors = 0, n_compared = 0, n, i;
  int          ms_tab[8] = '{4096, 1024, 256, 128, 64, 16, 4, 1};

  rwl_supervisor #(.WDOG_TICK_CYCLES(TICK), .WARM_POR_HI(POR_HI)) u_dut (
    .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cfg_osc_type(cfg_osc_type), .cfg_osc_range(cfg_osc_range),
    .cfg_wdog_enable(cfg_wdog_enable),
    .cfg_undervolt_enable(cfg_undervolt_enable),
    .cfg_undervolt_level(cfg_undervolt_level),
    .cfg_reset_pin_enable(cfg_reset_pin_enable),
    .reset_pin_b(reset_pin_b), .supply_low(supply_low),
    .comparator_result_bit(comparator_result_bit),
    .cmp_irq_enable(cmp_irq_enable), .port_irq(port_irq),
    .irq_pending(irq_pending), .halt_exec(halt_exec),
    .stop_exec(stop_exec), .sys_reset(sys_reset), .cpu_run(cpu_run),
    .osc_run(osc_run), .periph_run(periph_run), .isr_entry(isr_entry),
    .undervoltage_reset(undervoltage_reset),
    .undervoltage_threshold(undervoltage_threshold),
    .pin_port_bit(pin_port_bit));

  rwl_core_model core (
    .clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .halt_exec(halt_exec), .stop_exec(stop_exec));

  // 25 MHz
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  task automatic check(input logic [3:0] seen, input logic [3:0] want);
    n_compared++;
    if (seen !== want) begin
      n_errors++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic chk1(input logic seen, input logic want);
    check({3'h0, seen}, {3'h0, want});
  endtask

  // counts land a few cycles late through the pin synchronisers
  task automatic rng(input int v, input int lo);
    chk1(v >= lo && v <= lo + 12, 1'b1);
  endtask

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // waits for run or reset to rise, counting edges; bounded
  task automatic wait_hi(input bit on_run, output int cnt);
    cnt = 0;
    #1;
    while ((on_run ? cpu_run : sys_reset) !== 1'b1) begin
      @(posedge clk);
      #1;
      cnt++;
      if (cnt > 5000) begin
        check(4'h0, 4'h1);
        end_sim();
      end
    end
  endtask

  initial begin
    rst_b = 1'b0;
    {reset_pin_b, supply_low, comparator_result_bit} = 3'h4;
    {cmp_irq_enable, port_irq, irq_pending} = 3'h0;
    cfg_osc_type = OSC_EXT_CLK;
    {cfg_osc_range, cfg_wdog_enable, cfg_undervolt_enable} = 3'h7;
    cfg_reset_pin_enable = 1'b0;
    cfg_undervolt_level = lf[0];
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    wait_hi(1'b1, n);
    rng(n, POR_HI);
    chk1(undervoltage_threshold, cfg_undervolt_level);
    core.rd(ADDR_WDOG, d);
    check(d, 4'h0);
    $display("test power-on done");
    // random period codes; flag bit stays read-only
    for (i = 0; i < 8; i++) begin
      lf = lfsr_next(lf);
      d = {lf[3], lf[2:0] % 3'h6};
      core.wr(ADDR_WDOG, d);
      core.rd(ADDR_WDOG, d2);
      check(d2, {1'b0, d[2:0]});
    end
    core.rd(6'h05, d);
    check(d, 4'h0);
    $display("test registers done");
    // reads every 12 cycles keep a 16-cycle watchdog quiet
    core.wr(ADDR_WDOG, 4'h6);
    for (i = 0; i < 20; i++) begin
      repeat (10) @(posedge clk);
      core.rd(ADDR_WDOG, d);
      check(d, 4'h6);
    end
    $display("test restart done");
    // short periods overflow, reset, and leave the flag
    for (i = 7; i >= 5; i--) begin
      core.wr(ADDR_WDOG, 4'(i));
      wait_hi(1'b0, n);
      rng(n, ms_tab[i] * TICK - 2);
      wait_hi(1'b1, n);
      rng(n, WARM_FAST_RC_CYC - 1);
      core.rd(ADDR_WDOG, d);
      check(d, 4'h8);
    end
    $display("test overflow done");
    core.exec(1'b1, 1'b0);
    #1;
    check({cpu_run, periph_run, osc_run, 1'b0}, 4'h6);
    repeat (4) @(posedge clk);
    irq_pending <= 1'b1;
    @(posedge clk);
    irq_pending <= 1'b0;
    #1;
    check({cpu_run, isr_entry, 2'h0}, 4'hc);
    $display("test halt done");
    // stop woken by comparator, port, then watchdog
    for (i = 0; i < 3; i++) begin
      if (i == 2) core.wr(ADDR_WDOG, 4'h7);
      core.exec(1'b0, 1'b1);
      #1;
      check({osc_run, periph_run, cpu_run, 1'b0}, 4'h0);
      irq_pending <= (i == 0);
      cmp_irq_enable <= 1'b0;
      comparator_result_bit <= ~comparator_result_bit;
      repeat (12) @(posedge clk);
      irq_pending <= 1'b0;
      #1;
      chk1(osc_run, i == 2);
      cmp_irq_enable <= 1'b1;
      comparator_result_bit <= (i == 0) ^ comparator_result_bit;
      port_irq <= (i == 1);
      @(posedge clk);
      port_irq <= 1'b0;
      wait_hi(1'b1, n);
      rng(n, i == 2 ? WARM_FAST_RC_CYC - 14 : WARM_FAST_RC_CYC);
      chk1(isr_entry, i != 2);
    end
    core.rd(ADDR_WDOG, d);
    check(d, 4'h8);
    $display("test stop done");
    // undervoltage, then reset pin
    for (i = 0; i < 2; i++) begin
      supply_low <= (i == 0);
      reset_pin_b <= (i == 0);
      repeat (10) @(posedge clk);
      #1;
      check({sys_reset, undervoltage_reset, pin_port_bit, cpu_run},
            i == 0 ? 4'he : 4'ha);
      supply_low <= 1'b0;
      reset_pin_b <= 1'b1;
      wait_hi(1'b1, n);
      rng(n, i == 0 ? WARM_FAST_RC_CYC : POR_HI);
    end
    $display("test supply and pin done");
    // options turned off, low range, crystal
    rst_b <= 1'b0;
    {cfg_wdog_enable, cfg_undervolt_enable, cfg_osc_range} <= 3'h0;
    cfg_reset_pin_enable <= 1'b1;
    cfg_osc_type <= OSC_CRYSTAL;
    cfg_undervolt_level <= ~cfg_undervolt_level;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    wait_hi(1'b1, n);
    rng(n, WARM_POR_LO_CYC);
    chk1(undervoltage_threshold, cfg_undervolt_level);
    reset_pin_b <= 1'b0;
    supply_low <= 1'b1;
    core.wr(ADDR_WDOG, 4'h7);
    repeat (40) @(posedge clk);
    #1;
    check({sys_reset, pin_port_bit, 2'h0}, 4'h0);
    reset_pin_b <= 1'b1;
    supply_low <= 1'b0;
    core.exec(1'b0, 1'b1);
    port_irq <= 1'b1;
    @(posedge clk);
    port_irq <= 1'b0;
    wait_hi(1'b1, n);
    rng(n, WARM_FAST_XTL_CYC - 1);
    $display("test options done");
    end_sim();
  end
endmodule
